// ===== verilog/rcjl_unit.sv
// rcjl_unit: execution of the compact register call and its hazard-barrier form
// assumes decode presents one issue per cycle with the target register already read,
// and that the coprocessor-0 pipeline reports its outstanding writes as a level
`timescale 1ns/1ps
// Behaviour
// RULE1 - the plain compact call is recognised by major group, minor code and function fields.
// RULE2 - the barrier form is recognised by the same group and function with its own minor code.
// RULE3 - without the 32-bit mode a target bit 0 of zero flags an address error at target fetch, else bit 0 is cleared.
// RULE4 - with both modes the mode bit comes from target bit 0, bit 0 is cleared, and mode 0 needs 4-byte alignment.
// RULE5 - the jump's own address plus 4 is written to the register named by the link field.
// RULE6 - an omitted link register is carried as register 31 and the link goes there.
// RULE7 - no delay slot: younger instructions already fetched are discarded.
// RULE8 - the plain jump is the call with link register 0, whose write is dropped.
// RULE9 - a mode-0 target with address bit 1 set errors at target fetch, not at the jump.
// RULE10 - any instruction may follow the jump with no special handling.
// RULE11 - the barrier makes the target fetch and decode see all earlier coprocessor-0 changes.
// RULE12 - the barrier is accepted in every mode with no coprocessor-0 access check.
// RULE13 - the barrier stalls until coprocessor-0 writes have settled, then redirects fetch.
module rcjl_unit (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// configuration
	input wire logic has_word_mode,
	// issue from decode
	input wire rcjl_pkg::rcjl_issue_t issue,
	output logic [4:0] target_index,
	// coprocessor-0 state
	input wire logic cp0_writes_pending,
	// results
	output rcjl_pkg::rcjl_link_t link_q,
	output rcjl_pkg::rcjl_redirect_t redirect_q,
	output logic flush_q,
	output logic stall_q,
	output logic mode_q
);
	typedef enum logic [1:0] {RCJL_IDLE, RCJL_DRAIN, RCJL_FIRE} rcjl_state_t;

	logic is_call;
	logic is_barrier;
	logic [4:0] link_index;
	logic take;
	logic [63:0] tgt_addr;
	logic tgt_mode;
	logic tgt_err;
	rcjl_state_t state_q;
	logic [3:0] drain_q;
	logic [63:0] hold_addr_q;
	logic hold_mode_q;
	logic hold_err_q;

	rcjl_decode u_decode (
		.word(issue.word),
		.is_call(is_call),
		.is_barrier(is_barrier),
		.link_index(link_index),
		.target_index(target_index)
	);

	// a new jump is only taken while idle; during a barrier the stall holds decode
	assign take = issue.valid && (is_call || is_barrier) && (state_q == RCJL_IDLE); // [RULE12]

	always_comb begin
		tgt_addr = {issue.target_value[63:1], 1'b0}; // [RULE3] [RULE4]
		if (has_word_mode) begin
			tgt_mode = issue.target_value[0]; // [RULE4]
			// the error travels with the redirect so fetch raises it, not the jump
			tgt_err = !issue.target_value[0] && issue.target_value[1]; // [RULE4] [RULE9]
		end else begin
			tgt_mode = 1'b1;
			tgt_err = !issue.target_value[0]; // [RULE3]
		end
	end

	// link write: the zero register swallows the write for the plain jump
	always_ff @(posedge clock) begin
		if (rst) begin
			link_q <= '0;
		end else begin
			link_q.valid <= take && (link_index != rcjl_pkg::ZERO_REG); // [RULE8]
			link_q.index <= link_index; // [RULE6]
			link_q.data <= issue.pc + rcjl_pkg::RETURN_STEP; // [RULE5]
		end
	end

	// barrier sequencer: drain, then wait on coprocessor-0 writes, then redirect
	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= RCJL_IDLE;
			drain_q <= '0;
		end else begin
			unique case (state_q)
				RCJL_IDLE: begin
					if (take && is_barrier) begin
						state_q <= RCJL_DRAIN; // [RULE13]
						drain_q <= rcjl_pkg::DRAIN_CYCLES;
					end
				end
				RCJL_DRAIN: begin
					if (drain_q != 4'h0) begin
						drain_q <= drain_q - 4'h1;
					end else if (!cp0_writes_pending) begin
						state_q <= RCJL_FIRE; // [RULE11] [RULE13]
					end
				end
				RCJL_FIRE: begin
					state_q <= RCJL_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			hold_addr_q <= rcjl_pkg::PC_RESET;
			hold_mode_q <= 1'b0;
			hold_err_q <= 1'b0;
		end else if (take) begin
			hold_addr_q <= tgt_addr;
			hold_mode_q <= tgt_mode;
			hold_err_q <= tgt_err;
		end
	end

	// redirect: plain call at once, barrier only after the drain
	always_ff @(posedge clock) begin
		if (rst) begin
			redirect_q <= '0;
		end else if (take && is_call) begin
			redirect_q.valid <= 1'b1;
			redirect_q.addr <= tgt_addr;
			redirect_q.mode <= tgt_mode;
			redirect_q.addr_error <= tgt_err; // [RULE9]
		end else if (state_q == RCJL_FIRE) begin
			redirect_q.valid <= 1'b1; // [RULE13]
			redirect_q.addr <= hold_addr_q;
			redirect_q.mode <= hold_mode_q;
			redirect_q.addr_error <= hold_err_q;
		end else begin
			redirect_q.valid <= 1'b0;
		end
	end

	// younger work is flushed with the jump; nothing else about the next slot is special
	always_ff @(posedge clock) begin
		if (rst) begin
			flush_q <= 1'b0;
		end else begin
			flush_q <= take; // [RULE7] [RULE10]
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			stall_q <= 1'b0;
		end else begin
			stall_q <= (take && is_barrier) || (state_q == RCJL_DRAIN); // [RULE11]
		end
	end

	// active mode follows each redirect; a cpu without the word mode stays in the compact one
	always_ff @(posedge clock) begin
		if (rst) begin
			mode_q <= 1'b1;
		end else if (take && is_call) begin
			mode_q <= tgt_mode; // [RULE4]
		end else if (state_q == RCJL_FIRE) begin
			mode_q <= hold_mode_q;
		end
	end

	chk_link_return_step: assert property (@(posedge clock) disable iff (rst) // [RULE5]
		take |=> link_q.data == $past(issue.pc) + rcjl_pkg::RETURN_STEP)
		else $error("link data not pc plus 4");

	chk_zero_link_drop: assert property (@(posedge clock) disable iff (rst) // [RULE8]
		(take && link_index == rcjl_pkg::ZERO_REG) |=> !link_q.valid)
		else $error("zero register link written");

	chk_flush_on_jump: assert property (@(posedge clock) disable iff (rst) // [RULE7]
		take |=> flush_q)
		else $error("no flush after jump");

	chk_call_redirect_next: assert property (@(posedge clock) disable iff (rst) // [RULE1]
		(take && is_call) |=> redirect_q.valid && redirect_q.addr[0] == 1'b0)
		else $error("call redirect missing");

	sequence barrier_start_s;
		take && is_barrier;
	endsequence

	sequence barrier_hold_s;
		!redirect_q.valid [*2];
	endsequence

	chk_barrier_no_early: assert property (@(posedge clock) disable iff (rst) // [RULE13]
		barrier_start_s |=> barrier_hold_s)
		else $error("barrier redirected early");

	chk_barrier_waits_cp0: assert property (@(posedge clock) disable iff (rst) // [RULE11]
		(state_q == RCJL_DRAIN && cp0_writes_pending) |=> !redirect_q.valid)
		else $error("redirect while cp0 writes pending");

	chk_word_mode_error: assert property (@(posedge clock) disable iff (rst) // [RULE9]
		(take && is_call && has_word_mode && !issue.target_value[0] && issue.target_value[1])
		|=> redirect_q.addr_error && !flush_q == 1'b0)
		else $error("misaligned target not flagged");

	chk_no_word_mode_error: assert property (@(posedge clock) disable iff (rst) // [RULE3]
		(take && is_call && !has_word_mode) |=> redirect_q.addr_error == !$past(issue.target_value[0]))
		else $error("mode error wrong");

	sequence barrier_drain_s;
		(state_q == RCJL_DRAIN) [*3];
	endsequence

	chk_redirect_bit0_clear: assert property (@(posedge clock) disable iff (rst) // [RULE3]
		redirect_q.valid |-> !redirect_q.addr[0])
		else $error("redirect bit 0 not cleared");

	chk_link_index_field: assert property (@(posedge clock) disable iff (rst) // [RULE6]
		take |=> link_q.index == $past(link_index))
		else $error("link index not from link field");

	chk_link_nonzero_write: assert property (@(posedge clock) disable iff (rst) // [RULE5]
		(take && link_index != rcjl_pkg::ZERO_REG) |=> link_q.valid)
		else $error("link write missing");

	chk_link_single_pulse: assert property (@(posedge clock) disable iff (rst) // [RULE5]
		(link_q.valid && !take) |=> !link_q.valid)
		else $error("link write repeated");

	chk_no_take_no_flush: assert property (@(posedge clock) disable iff (rst) // [RULE7]
		!take |=> !flush_q)
		else $error("flush without jump");

	chk_stray_word_ignored: assert property (@(posedge clock) disable iff (rst) // [RULE1]
		(issue.valid && !is_call && !is_barrier) |=> !flush_q && !link_q.valid)
		else $error("stray word acted on");

	chk_busy_issue_ignored: assert property (@(posedge clock) disable iff (rst) // [RULE13]
		(state_q == RCJL_DRAIN && issue.valid) |=> !flush_q)
		else $error("issue taken during barrier");

	chk_stall_after_barrier: assert property (@(posedge clock) disable iff (rst) // [RULE13]
		barrier_start_s |=> stall_q)
		else $error("no stall after barrier");

	chk_stall_in_drain: assert property (@(posedge clock) disable iff (rst) // [RULE13]
		(state_q == RCJL_DRAIN) |=> stall_q)
		else $error("stall dropped while draining");

	chk_idle_no_stall: assert property (@(posedge clock) disable iff (rst) // [RULE10]
		(state_q == RCJL_IDLE && !take) |=> !stall_q)
		else $error("stall while idle");

	chk_barrier_drain_len: assert property (@(posedge clock) disable iff (rst) // [RULE13]
		barrier_start_s |=> barrier_drain_s)
		else $error("barrier drain too short");

	chk_drain_counts_down: assert property (@(posedge clock) disable iff (rst) // [RULE13]
		(state_q == RCJL_DRAIN && drain_q != 4'h0) |=> state_q == RCJL_DRAIN)
		else $error("drain left before count ran out");

	chk_fire_from_drain: assert property (@(posedge clock) disable iff (rst) // [RULE11]
		(state_q == RCJL_FIRE) |-> $past(state_q) == RCJL_DRAIN && !$past(cp0_writes_pending))
		else $error("fire without settled cp0 writes");

	chk_fire_redirects: assert property (@(posedge clock) disable iff (rst) // [RULE13]
		(state_q == RCJL_FIRE) |=> redirect_q.valid && !stall_q)
		else $error("barrier fire without redirect");

	chk_barrier_bound: assert property (@(posedge clock) disable iff (rst) // [RULE13]
		(barrier_start_s ##1 (!cp0_writes_pending) [*3]) |=> ##1 redirect_q.valid)
		else $error("barrier redirect late");

	chk_barrier_keeps_target: assert property (@(posedge clock) disable iff (rst) // [RULE11]
		(state_q == RCJL_FIRE) |=> redirect_q.addr == $past(hold_addr_q))
		else $error("barrier target lost");

	chk_target_addr: assert property (@(posedge clock) disable iff (rst) // [RULE4]
		(take && is_call) |=> redirect_q.addr[63:1] == $past(issue.target_value[63:1]))
		else $error("call target wrong");

	chk_word_mode_bit: assert property (@(posedge clock) disable iff (rst) // [RULE4]
		(take && is_call && has_word_mode) |=> redirect_q.mode == $past(issue.target_value[0]))
		else $error("mode bit not from target bit 0");

	chk_no_word_mode_stays: assert property (@(posedge clock) disable iff (rst) // [RULE3]
		(!has_word_mode && redirect_q.valid) |-> redirect_q.mode)
		else $error("unsupported mode selected");

	chk_compact_target_ok: assert property (@(posedge clock) disable iff (rst) // [RULE9]
		(take && is_call && has_word_mode && issue.target_value[0]) |=> !redirect_q.addr_error)
		else $error("compact target flagged");

	chk_mode_follows_call: assert property (@(posedge clock) disable iff (rst) // [RULE4]
		(take && is_call) |=> mode_q == redirect_q.mode)
		else $error("mode register not updated by call");

	chk_mode_on_fire: assert property (@(posedge clock) disable iff (rst) // [RULE4]
		(state_q == RCJL_FIRE) |=> mode_q == redirect_q.mode)
		else $error("mode register not updated by barrier");
endmodule

// ===== verilog/rcjl_pkg.sv
// rcjl_pkg: encodings, field positions and carrier structs for the compact register call unit
// assumes a 64-bit general register file and 32-bit instruction words
package rcjl_pkg;
	localparam int XLEN = 64;
	localparam int OP_MSB = 31;
	localparam int OP_LSB = 26;
	localparam int LINK_MSB = 25;
	localparam int LINK_LSB = 21;
	localparam int TGT_MSB = 20;
	localparam int TGT_LSB = 16;
	localparam int MINOR_MSB = 15;
	localparam int MINOR_LSB = 6;
	localparam int FUNC_MSB = 5;
	localparam int FUNC_LSB = 0;
	localparam logic [5:0] MAJOR_GROUP_CODE = 6'h00;
	localparam logic [5:0] MINOR_FUNCTION_GROUP = 6'h3c;
	localparam logic [9:0] MINOR_CALL = 10'h03c;
	localparam logic [9:0] MINOR_CALL_BARRIER = 10'h07c;
	localparam logic [4:0] LINK_DEFAULT = 5'h1f;
	localparam logic [4:0] ZERO_REG = 5'h00;
	localparam logic [63:0] RETURN_STEP = 64'h4;
	localparam logic [63:0] PC_RESET = 64'h0;
	localparam logic [3:0] DRAIN_CYCLES = 4'h2;

	typedef struct packed {
		logic valid;
		logic [31:0] word;
		logic [63:0] pc;
		logic [63:0] target_value;
	} rcjl_issue_t;

	typedef struct packed {
		logic valid;
		logic [63:0] addr;
		logic mode;
		logic addr_error;
	} rcjl_redirect_t;

	typedef struct packed {
		logic valid;
		logic [4:0] index;
		logic [63:0] data;
	} rcjl_link_t;
endpackage

// ===== verilog/rcjl_decode.sv
// rcjl_decode: combinational recogniser for the two compact register call encodings
// assumes the instruction word is stable while valid is high
`timescale 1ns/1ps
module rcjl_decode (
	// instruction in
	input wire logic [31:0] word,
	// decode results
	output logic is_call,
	output logic is_barrier,
	output logic [4:0] link_index,
	output logic [4:0] target_index
);
	logic group_ok;
	assign group_ok = (word[rcjl_pkg::OP_MSB:rcjl_pkg::OP_LSB] == rcjl_pkg::MAJOR_GROUP_CODE) &&
		(word[rcjl_pkg::FUNC_MSB:rcjl_pkg::FUNC_LSB] == rcjl_pkg::MINOR_FUNCTION_GROUP);
	assign is_call = group_ok &&
		(word[rcjl_pkg::MINOR_MSB:rcjl_pkg::MINOR_LSB] == rcjl_pkg::MINOR_CALL); // [RULE1]
	assign is_barrier = group_ok &&
		(word[rcjl_pkg::MINOR_MSB:rcjl_pkg::MINOR_LSB] == rcjl_pkg::MINOR_CALL_BARRIER); // [RULE2]
	// register 31 arrives from the assembler when the link is omitted; register 0 is the plain jump
	assign link_index = word[rcjl_pkg::LINK_MSB:rcjl_pkg::LINK_LSB]; // [RULE6] [RULE8]
	assign target_index = word[rcjl_pkg::TGT_MSB:rcjl_pkg::TGT_LSB];
endmodule

// ===== tb/rcjl_gpr_model.sv
// rcjl_gpr_model: register file on the decode side, read for the jump target
// assumes reads are combinational and writes land on the clock edge
`timescale 1ns/1ps
module rcjl_gpr_model (
	// clock
	input wire logic clock,
	// read port
	input wire logic [4:0] rd_index,
	output logic [63:0] rd_value,
	// link result and bench preload
	input wire rcjl_pkg::rcjl_link_t link,
	input wire logic pre_en,
	input wire logic [4:0] pre_index,
	input wire logic [63:0] pre_value
);
	logic [63:0] gpr [32];
	always @(posedge clock) begin
		if (pre_en) begin
			gpr[pre_index] <= pre_value;
		end else if (link.valid) begin
			gpr[link.index] <= link.data;
		end
	end
	// register 0 reads zero, so a link aimed there is lost
	assign rd_value = (rd_index == 5'h00) ? 64'h0 : gpr[rd_index];
endmodule

// ===== tb/compact_register_jump_link_tb.sv
// compact_register_jump_link_tb: random calls, barriers and stray words against rcjl_unit
// assumes the register model answers reads in the same cycle
`timescale 1ns/1ps
module compact_register_jump_link_tb;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic has_word_mode = 1'b0;
	logic cp0_writes_pending = 1'b0;
	logic iss_valid = 1'b0;
	logic [31:0] iss_word = 32'h0;
	logic [63:0] iss_pc = 64'h0;
	logic pre_en = 1'b0;
	logic [4:0] pre_index = 5'h0;
	logic [63:0] pre_value = 64'h0;
	logic [63:0] tv;
	logic [4:0] target_index;
	rcjl_pkg::rcjl_issue_t issue;
	rcjl_pkg::rcjl_link_t link_q;
	rcjl_pkg::rcjl_redirect_t redirect_q;
	logic flush_q;
	logic stall_q;
	logic mode_q;
	logic [31:0] seed = 32'h31fa1d4b;
	int n_fail = 0;
	int check_count = 0;
	assign issue = '{valid: iss_valid, word: iss_word, pc: iss_pc, target_value: tv};
	always #4 clock = ~clock;
	rcjl_unit i_dut (.clock(clock), .rst(rst), .has_word_mode(has_word_mode), .issue(issue),
		.target_index(target_index), .cp0_writes_pending(cp0_writes_pending), .link_q(link_q),
		.redirect_q(redirect_q), .flush_q(flush_q), .stall_q(stall_q), .mode_q(mode_q));
	rcjl_gpr_model i_gpr (.clock(clock), .rd_index(target_index), .rd_value(tv), .link(link_q),
		.pre_en(pre_en), .pre_index(pre_index), .pre_value(pre_value));
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic finish_test();
		if (n_fail == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// preload the target register one cycle early so the read is settled at the take edge
	task automatic jump(input logic [9:0] mn, input logic [4:0] lk, input logic [4:0] tg, input logic [63:0] v,
		input int hold);
		logic [63:0] pc;
		logic hit;
		int n;
		pc = {32'h0, seed[31:2], 2'b00};
		hit = (mn == rcjl_pkg::MINOR_CALL) || (mn == rcjl_pkg::MINOR_CALL_BARRIER);
		@(posedge clock);
		pre_en <= 1'b1;
		pre_index <= tg;
		pre_value <= v;
		@(posedge clock);
		pre_en <= 1'b0;
		iss_valid <= 1'b1;
		iss_word <= {rcjl_pkg::MAJOR_GROUP_CODE, lk, tg, mn, rcjl_pkg::MINOR_FUNCTION_GROUP};
		iss_pc <= pc;
		cp0_writes_pending <= (hold > 0);
		@(posedge clock);
		iss_valid <= 1'b0;
		#1;
		chk("flush", hit, flush_q);
		chk("link valid", hit && lk != 5'h00, link_q.valid);
		chk("redirect early", mn == rcjl_pkg::MINOR_CALL, redirect_q.valid);
		if (!hit) begin
			cp0_writes_pending <= 1'b0;
			return;
		end
		if (lk != 5'h00) begin
			chk("link index", lk, link_q.index);
			chk("link data", pc + rcjl_pkg::RETURN_STEP, link_q.data);
		end
		n = 1;
		while (redirect_q.valid !== 1'b1 && n < 40) begin
			chk("stall", 1'b1, stall_q);
			if (n >= hold) begin
				cp0_writes_pending <= 1'b0;
			end
			@(posedge clock);
			#1;
			n++;
		end
		if (mn == rcjl_pkg::MINOR_CALL_BARRIER) begin
			chk("barrier wait", 1'b1, n >= 5 && n > hold + 1 && n < 40);
		end
		chk("target", {v[63:1], 1'b0}, redirect_q.addr);
		chk("mode", has_word_mode ? v[0] : 1'b1, redirect_q.mode);
		chk("mode reg", has_word_mode ? v[0] : 1'b1, mode_q);
		chk("addr error", has_word_mode ? (!v[0] && v[1]) : !v[0], redirect_q.addr_error);
	endtask
	initial begin
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		#1;
		chk("mode after reset", 1'b1, mode_q);
		chk("redirect after reset", 1'b0, redirect_q.valid);
		for (int i = 0; i < 64; i++) begin
			seed = xorshift(seed);
			has_word_mode <= i[5];
			jump(i[1:0] == 2'h0 ? rcjl_pkg::MINOR_CALL_BARRIER : (i[2:0] == 3'h3 ? seed[15:6] : rcjl_pkg::MINOR_CALL),
				i[3:0] == 4'h5 ? rcjl_pkg::ZERO_REG : (i[4] ? rcjl_pkg::LINK_DEFAULT : seed[25:21]),
				seed[20:16] | 5'h01, {xorshift(seed), seed}, int'(seed[9:8]));
		end
		finish_test();
	end
	// runs end well inside this span; each jump needs at most about 45 cycles
	initial begin
		repeat (6000) @(posedge clock);
		n_fail++;
		finish_test();
	end
endmodule
